// ==== hw/dac_ctrl.sv ====
// converter register control: data registers, input control, trigger and start logic
// assumes a synchronous converter core and timer overflow pulses on clk_i
//
// Function
// - result word split over two byte registers
// - reference bit picks internal or supply reference
// - differential bit picks differential or single-ended
// - connect bit zero keeps inputs disconnected
// - left-align zero-fills, right-align sign-extends
// - start bit begins conversion when the trigger field selects software start, cleared when done
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "dac_regs.svh"
`default_nettype none
module dac_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // axi4-lite write address
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_awaddr_i,
    // axi4-lite write data
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // axi4-lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // axi4-lite read address
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [31:0] s_axi_araddr_i,
    // axi4-lite read data
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // timer overflow pulses
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    // converter core
    output var dac_pkg::dac_analog_ctl_t analog_ctl_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [`DAC_RESULT_W-1:0] conv_result_i
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx == `DAC_IDX_CONTROL) || (idx == `DAC_IDX_INPUT_CONTROL) ||
                     (idx == `DAC_IDX_DATA_LOW) || (idx == `DAC_IDX_DATA_HIGH);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam logic [7:0] ctl_rst = `DAC_RST_CONTROL;
    dac_pkg::dac_input_ctl_t in_ctl_q;
    logic [7:0] data_low_q;
    logic [7:0] data_high_q;
    logic left_align_bit_q;
    logic busy_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_idx_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic wr_fire;
    logic wr_ok;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic [7:0] ctl_rd;
    logic hw_trig;
    logic sw_start;
    logic start;
    logic [15:0] result_word;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
    assign wr_ok = idx_mapped(aw_idx_q);
    assign rd_idx = reg_index(s_axi_araddr_i);

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    // address and data are taken in either order; the response follows both
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            aw_have_q <= 1'b0;
            aw_idx_q <= 8'h00;
        end
        else if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            aw_have_q <= 1'b1;
            aw_idx_q <= reg_index(s_axi_awaddr_i);
        end
        else if (wr_fire)
        begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            w_have_q <= 1'b0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
        end
        else if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_i[7:0];
            wlane_q <= s_axi_wstrb_i[0];
        end
        else if (wr_fire)
        begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end
        else
        begin
            s_axi_awready_o <= !aw_have_q && !(s_axi_awvalid_i && s_axi_awready_o);
            s_axi_wready_o <= !w_have_q && !(s_axi_wvalid_i && s_axi_wready_o);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= dac_pkg::DAC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? dac_pkg::DAC_RESP_OKAY : dac_pkg::DAC_RESP_SLVERR;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // channel changes with the input still connected are not blocked; software keeps it off
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            in_ctl_q <= `DAC_RST_INPUT_CONTROL;
        end
        else if (wr_fire && wlane_q && aw_idx_q == `DAC_IDX_INPUT_CONTROL)
        begin
            in_ctl_q <= wdata_q;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            left_align_bit_q <= ctl_rst[`DAC_CTL_LEFT_ALIGN_BIT_BIT];
        end
        else if (wr_fire && wlane_q && aw_idx_q == `DAC_IDX_CONTROL)
        begin
            left_align_bit_q <= wdata_q[`DAC_CTL_LEFT_ALIGN_BIT_BIT];
        end
    end

    // ----------------------------------------
    // trigger and busy
    // ----------------------------------------
    always_comb
    begin
        case (dac_pkg::dac_trg_t'(in_ctl_q.trg))
            dac_pkg::DAC_TRG_T0: hw_trig = timer0_ovf_i;
            dac_pkg::DAC_TRG_T1: hw_trig = timer1_ovf_i;
            dac_pkg::DAC_TRG_T2: hw_trig = timer2_ovf_i;
            default: hw_trig = 1'b0;
        endcase
    end

    assign sw_start = wr_fire && wlane_q && aw_idx_q == `DAC_IDX_CONTROL &&
                      wdata_q[`DAC_CTL_BUSY_BIT] && in_ctl_q.trg == 2'b00;
    // a start in the completion cycle wins over the clear
    assign start = (sw_start || hw_trig) && (!busy_q || conv_done_i);

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            busy_q <= 1'b0;
        end
        else if (start)
        begin
            busy_q <= 1'b1;
        end
        else if (conv_done_i)
        begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            conv_start_o <= 1'b0;
        end
        else
        begin
            conv_start_o <= start;
        end
    end

    // ----------------------------------------
    // result capture
    // ----------------------------------------
    always_comb
    begin
        if (left_align_bit_q)
        begin
            result_word = {conv_result_i, {`DAC_LEFT_ALIGN_BIT_PAD{1'b0}}};
        end
        else
        begin
            result_word = {{`DAC_LEFT_ALIGN_BIT_PAD{conv_result_i[`DAC_RESULT_W-1]}}, conv_result_i};
        end
    end

    // result lands over any software write in the same cycle
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_low_q <= `DAC_RST_DATA_LOW;
            data_high_q <= `DAC_RST_DATA_HIGH;
        end
        else if (conv_done_i && busy_q)
        begin
            data_low_q <= result_word[7:0];
            data_high_q <= result_word[15:8];
        end
        else if (wr_fire && wlane_q)
        begin
            if (aw_idx_q == `DAC_IDX_DATA_LOW)
            begin
                data_low_q <= wdata_q;
            end
            if (aw_idx_q == `DAC_IDX_DATA_HIGH)
            begin
                data_high_q <= wdata_q;
            end
        end
    end

    // ----------------------------------------
    // analog control
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            analog_ctl_o <= '0;
        end
        else
        begin
            analog_ctl_o.connect <= in_ctl_q.connect;
            analog_ctl_o.ref_internal <= in_ctl_q.ref_internal;
            analog_ctl_o.differential_enable_bit <= in_ctl_q.differential_enable_bit;
            analog_ctl_o.mux_code <= {in_ctl_q.differential_enable_bit, in_ctl_q.acs};
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    assign ctl_rd = {1'b0, busy_q, 2'b00, left_align_bit_q, 3'b000};

    always_comb
    begin
        case (rd_idx)
            `DAC_IDX_CONTROL: rd_val = ctl_rd;
            `DAC_IDX_INPUT_CONTROL: rd_val = in_ctl_q;
            `DAC_IDX_DATA_LOW: rd_val = data_low_q;
            `DAC_IDX_DATA_HIGH: rd_val = data_high_q;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_arready_o <= 1'b0;
        end
        else
        begin
            s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= dac_pkg::DAC_RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {24'h00_0000, rd_val};
            s_axi_rresp_o <= idx_mapped(rd_idx) ? dac_pkg::DAC_RESP_OKAY : dac_pkg::DAC_RESP_SLVERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule // dac_ctrl
`default_nettype wire

// ==== hw/dac_pkg.sv ====
// types shared by the converter control block
// assumes dac_regs.svh holds the numbers
`default_nettype none
package dac_pkg;
    typedef enum logic [1:0] {
        DAC_TRG_SOFT,
        DAC_TRG_T0,
        DAC_TRG_T1,
        DAC_TRG_T2
    } dac_trg_t;

    typedef struct packed {
        logic connect;
        logic ref_internal;
        logic differential_enable_bit;
        logic [1:0] trg;
        logic [2:0] acs;
    } dac_input_ctl_t;

    typedef struct packed {
        logic connect;
        logic ref_internal;
        logic differential_enable_bit;
        logic [3:0] mux_code;
    } dac_analog_ctl_t;

    typedef enum logic [1:0] {
        DAC_RESP_OKAY = 2'b00,
        DAC_RESP_SLVERR = 2'b10
    } dac_resp_t;
endpackage
`default_nettype wire

// ==== hw/dac_regs.svh ====
// register indices, field positions, reset values for the converter control block
// assumes byte address = 4 * index on a 32-bit axi4-lite bus
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define DAC_IDX_CONTROL 8'hd8
`define DAC_IDX_INPUT_CONTROL 8'hda
`define DAC_IDX_DATA_LOW 8'hdc
`define DAC_IDX_DATA_HIGH 8'hdd
// ----------------------------------------
// input control fields
// ----------------------------------------
`define DAC_IC_CONNECT_BIT 7
`define DAC_IC_REF_BIT 6
`define DAC_IC_DIFFERENTIAL_ENABLE_BIT_BIT 5
`define DAC_IC_TRG_HI 4
`define DAC_IC_TRG_LO 3
`define DAC_IC_ACS_HI 2
`define DAC_IC_ACS_LO 0
// ----------------------------------------
// control fields
// ----------------------------------------
`define DAC_CTL_BUSY_BIT 6
`define DAC_CTL_LEFT_ALIGN_BIT_BIT 3
// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define DAC_RST_INPUT_CONTROL 8'h00
`define DAC_RST_DATA_LOW 8'h00
`define DAC_RST_DATA_HIGH 8'h00
`define DAC_RST_CONTROL 8'h00
`define DAC_RESULT_W 10
`define DAC_LEFT_ALIGN_BIT_PAD 6
`endif

// ==== tb/dac_ctrl_assertions.sv ====
// concurrent checks on the converter control block ports
// assumes one clock clk_i and active-high reset sys_rst_i
`default_nettype none
module dac_ctrl_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // converter side
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    input wire dac_pkg::dac_analog_ctl_t analog_ctl_o,
    input wire logic conv_start_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    logic ovf_any;
    assign ovf_any = timer0_ovf_i | timer1_ovf_i | timer2_ovf_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_MUX_CODE: assert property (analog_ctl_o[4] == analog_ctl_o[3])
        else $error("mux code top bit differs");
    AST_START_ONE: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    // a start needs a write answer or a timer pulse behind it
    // start and write answer rise on one edge; a timer start follows its pulse by one edge
    AST_START_CAUSE: assert property (conv_start_o |-> $rose(s_axi_bvalid_o) || $past(ovf_any))
        else $error("start without cause");
    AST_R_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    AST_AR_R: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    AST_W_B: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o)
        else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read answer dropped");
    COV_START: cover property (conv_start_o);
    COV_WRITE: cover property (s_axi_bvalid_o && s_axi_bready_i);
    COV_READ: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // dac_ctrl_assertions
bind dac_ctrl dac_ctrl_assertions u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
    .timer0_ovf_i(timer0_ovf_i), .timer1_ovf_i(timer1_ovf_i), .timer2_ovf_i(timer2_ovf_i),
    .analog_ctl_o(analog_ctl_o), .conv_start_o(conv_start_o));
`default_nettype wire

// ==== tb/dac_ctrl_tb_top.sv ====
// self-checking bench for the converter control block
// assumes byte address = 4 * index and a checker bound to the block
`default_nettype none
module dac_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] a_ctl = 32'h0000_0360;
    localparam logic [31:0] a_ic = 32'h0000_0368;
    localparam logic [31:0] a_lo = 32'h0000_0370;
    localparam logic [31:0] a_hi = 32'h0000_0374;
    typedef struct { logic [7:0] ic; logic [6:0] an; } dac_row_t;
    dac_row_t rows [5] = '{'{8'h00, 7'h00}, '{8'he5, 7'h7d}, '{8'h47, 7'h27}, '{8'h83, 7'h43}, '{8'h03, 7'h03}};
    logic [7:0] ic_last = 8'h00;
    logic [3:0] ws = 4'h1;
    logic clk_i = 0, rst = 1, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0, t0 = 0, t1 = 0, t2 = 0, dn = 0;
    logic [31:0] aa = 0, wd = 0, ra = 0, rd_v, rdat;
    logic [9:0] res = 0;
    logic awr, wr_r, bv, arr, rv, cs;
    logic [1:0] br, rr, resp;
    dac_pkg::dac_analog_ctl_t ana;
    int fail_count = 0, checks = 0, cyc = 0, starts = 0;
    dac_ctrl dut (.clk_i(clk_i), .sys_rst_i(rst), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_awaddr_i(aa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv), .s_axi_bready_i(bq), .s_axi_bresp_o(br),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ra), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rq), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .timer0_ovf_i(t0),
        .timer1_ovf_i(t1), .timer2_ovf_i(t2), .analog_ctl_o(ana), .conv_start_o(cs),
        .conv_done_i(dn), .conv_result_i(res));
    initial forever #10 clk_i = ~clk_i;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        cyc++;
        if (cs === 1'b1) starts++;
        if (cyc == 5000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task report_and_stop();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // valid and payload stay up until each ready is sampled high
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        aa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bq <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_r === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        resp = br;
        bq <= 1'b0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge clk_i);
        ra <= a;
        arv <= 1'b1;
        rq <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rd_v = rdat;
        resp = rr;
        rq <= 1'b0;
    endtask
    task done(input logic [9:0] v);
        @(posedge clk_i);
        dn <= 1'b1;
        res <= v;
        @(posedge clk_i);
        dn <= 1'b0;
    endtask
    task tick(input int n);
        @(posedge clk_i);
        {t2, t1, t0} <= 3'b001 << n;
        @(posedge clk_i);
        {t2, t1, t0} <= 3'b000;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            // channel only moves while the input is disconnected
            wr(a_ic, {24'h00_0000, 1'b0, ic_last[6:0]});
            wr(a_ic, {24'h00_0000, 1'b0, rows[i].ic[6:0]});
            wr(a_ic, {24'h00_0000, rows[i].ic});
            ic_last = rows[i].ic;
            rd(a_ic);
            chk(rd_v, {24'h00_0000, rows[i].ic});
            chk({25'h000_0000, ana}, {25'h000_0000, rows[i].an});
        end
        $display("input control rows done");
        wr(a_ic, 32'h0000_0000);
        wr(a_ctl, 32'h0000_0048);
        wr(a_ctl, 32'h0000_0048);
        rd(a_ctl);
        chk(rd_v, 32'h0000_0048);
        chk(starts, 1);
        done(10'h2a5);
        rd(a_hi);
        chk(rd_v, 32'h0000_00a9);
        rd(a_lo);
        chk(rd_v, 32'h0000_0040);
        wr(a_ctl, 32'h0000_0040);
        done(10'h2a5);
        rd(a_hi);
        chk(rd_v, 32'h0000_00fe);
        rd(a_lo);
        chk(rd_v, 32'h0000_00a5);
        rd(a_ctl);
        chk(rd_v, 32'h0000_0000);
        $display("software start done");
        // soft start and the wrong timer must both be ignored
        for (int n = 0; n < 3; n++)
        begin
            wr(a_ic, 32'((n + 1) << 3));
            wr(a_ctl, 32'h0000_0040);
            tick((n + 1) % 3);
            chk(starts, 2 + n);
            tick(n);
            rd(a_ctl);
            chk(rd_v, 32'h0000_0040);
            chk(starts, 3 + n);
            done(10'h001);
        end
        $display("timer triggers done");
        rd(32'h0000_0000);
        chk({rd_v[29:0], resp}, 32'h0000_0002);
        wr(32'h0000_0004, 32'h0000_00ff);
        chk({30'h0000_0000, resp}, 32'h0000_0002);
        $display("unmapped access done");
        wr(a_hi, 32'h0000_005a);
        ws <= 4'h0;
        wr(a_hi, 32'h0000_00ff);
        ws <= 4'h1;
        rd(a_hi);
        chk(rd_v, 32'h0000_005a);
        $display("data register write done");
        @(posedge clk_i);
        rst <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            rd(k == 0 ? a_ic : (k == 1 ? a_lo : a_hi));
            chk(rd_v, 32'h0000_0000);
        end
        chk({25'h000_0000, ana}, 32'h0000_0000);
        $display("reset values done");
        report_and_stop();
    end
endmodule // dac_ctrl_tb_top
`default_nettype wire
